// ===== common/cst_pkg.sv
// Constants, types and helpers shared by the subtract/trap/transfer decoder
`default_nettype none
package cst_pkg;
   localparam logic [7:0] OP_TRAP = 8'h83;
   localparam logic [7:0] OP_A2X = 8'h97;
   localparam logic [7:0] OP_X2A = 8'h9f;
   localparam logic [7:0] OP_WAIT = 8'h8f;
   localparam logic [7:0] OP_TEST_ACC = 8'h4d;
   localparam logic [7:0] OP_TEST_IDX = 8'h5d;
   localparam logic [3:0] LO_SUB = 4'h0;
   localparam logic [3:0] LO_TEST = 4'hd;
   localparam logic [3:0] HI_IMMED = 4'ha;
   localparam logic [3:0] HI_DIR = 4'hb;
   localparam logic [3:0] HI_EXTD = 4'hc;
   localparam logic [3:0] HI_XLONG = 4'hd;
   localparam logic [3:0] HI_XSHORT = 4'he;
   localparam logic [3:0] HI_XPLAIN = 4'hf;
   localparam logic [3:0] HI_TEST_DIR = 4'h3;
   localparam logic [3:0] HI_TEST_XSHORT = 4'h6;
   localparam logic [3:0] HI_TEST_XPLAIN = 4'h7;
   localparam int CC_C = 0;
   localparam int CC_Z = 1;
   localparam int CC_N = 2;
   localparam int CC_I = 3;
   localparam logic [7:0] CC_RST = 8'hf8;
   localparam logic [7:0] STK_RST = 8'hff;
   localparam logic [15:0] PC_RST = 16'h0100;
   localparam logic [15:0] VEC_HI = 16'hfffc;
   localparam logic [15:0] VEC_LO = 16'hfffd;
   localparam logic [7:0] PAGE0 = 8'h00;
   localparam logic [15:0] ONE16 = 16'h0001;
   localparam logic [7:0] ONE8 = 8'h01;
   localparam logic [7:0] ZERO8 = 8'h00;
   localparam int TRAP_CYCLES = 10;
   localparam int XFER_CYCLES = 2;

   typedef enum logic [3:0] {
      S_FETCH, S_DEC, S_LO, S_EXEC, S_PUSH_LO, S_PUSH_HI, S_PUSH_X,
      S_PUSH_A, S_PUSH_CC, S_VHI, S_VLO, S_VDN, S_WAIT
   } cst_state_t;

   typedef enum logic [2:0] {
      M_NONE, M_IMMED, M_DIR, M_EXTD, M_XLONG, M_XSHORT, M_XPLAIN
   } cst_mode_t;

   function automatic logic is_sub(input logic [7:0] op);
      is_sub = (op[3:0] == LO_SUB) && (op[7:4] >= HI_IMMED);
   endfunction : is_sub

   function automatic cst_mode_t mode_of(input logic [7:0] op);
      mode_of = M_NONE;
      if (op[3:0] == LO_SUB) begin
         unique case (op[7:4])
            HI_IMMED: mode_of = M_IMMED;
            HI_DIR: mode_of = M_DIR;
            HI_EXTD: mode_of = M_EXTD;
            HI_XLONG: mode_of = M_XLONG;
            HI_XSHORT: mode_of = M_XSHORT;
            HI_XPLAIN: mode_of = M_XPLAIN;
            default: mode_of = M_NONE;
         endcase
      end else if (op[3:0] == LO_TEST) begin
         unique case (op[7:4])
            HI_TEST_DIR: mode_of = M_DIR;
            HI_TEST_XSHORT: mode_of = M_XSHORT;
            HI_TEST_XPLAIN: mode_of = M_XPLAIN;
            default: mode_of = M_NONE;
         endcase
      end
   endfunction : mode_of

   function automatic logic [7:0] set_nz(input logic [7:0] cc,
                                         input logic [7:0] v);
      set_nz = cc;
      set_nz[CC_N] = v[7];
      set_nz[CC_Z] = (v == ZERO8);
   endfunction : set_nz
endpackage : cst_pkg
`default_nettype wire

// ===== hw/cst_decoder.sv
// CPU core slice: subtract, trap, transfers, test and wait
`timescale 1ns/10ps
`default_nettype none
module cst_decoder
   import cst_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_reset,
   input wire logic [7:0] i_mem_rdata,
   input wire logic i_wake,
   output logic [15:0] o_mem_addr,
   output logic [7:0] o_mem_wdata,
   output logic o_mem_we,
   output logic [7:0] o_acc,
   output logic [7:0] o_index,
   output logic [7:0] o_stack_ptr,
   output logic [15:0] o_pc,
   output logic [7:0] o_cond_codes,
   output logic o_wait
);
   typedef struct packed {
      cst_state_t st;
      logic [7:0] acc;
      logic [7:0] idx;
      logic [7:0] stk;
      logic [15:0] pc;
      logic [7:0] cond;
      logic [7:0] opc;
      logic [7:0] hi;
      logic [15:0] addr;
      logic [7:0] wdata;
      logic we;
      logic wt;
      logic wake_s1;
      logic wake_s2;
   } cst_core_t;

   cst_core_t s_reg;
   cst_core_t s_next;
   logic [7:0] diff;
   logic borrow;
   cst_mode_t mode;
   logic [15:0] pc_inc;
   logic [7:0] stk_dec;

   cst_sub_alu u_alu (
      .i_a(s_reg.acc),
      .i_b(i_mem_rdata),
      .o_diff(diff),
      .o_borrow(borrow)
   );

   ////////////////////////////////////////////////////////////////////////
   // Next state
   always_comb begin
      s_next = s_reg;
      mode = mode_of(s_reg.opc);
      pc_inc = s_reg.pc + ONE16;
      stk_dec = s_reg.stk - ONE8;
      s_next.we = 1'b0;
      s_next.wake_s1 = i_wake;
      s_next.wake_s2 = s_reg.wake_s1;
      if (i_reset) begin
         s_next.st = S_FETCH;
         s_next.acc = ZERO8;
         s_next.idx = ZERO8;
         s_next.stk = STK_RST;
         s_next.pc = PC_RST;
         s_next.cond = CC_RST;
         s_next.opc = ZERO8;
         s_next.hi = ZERO8;
         s_next.addr = PC_RST;
         s_next.wdata = ZERO8;
         s_next.wt = 1'b0;
         s_next.wake_s1 = 1'b0;
         s_next.wake_s2 = 1'b0;
      end else begin
         unique case (s_reg.st)
            S_FETCH: begin
               s_next.opc = i_mem_rdata;
               s_next.pc = pc_inc;
               s_next.addr = pc_inc;
               s_next.st = S_DEC;
            end
            S_DEC: begin
               s_next.st = S_FETCH;
               if (s_reg.opc == OP_TRAP) begin
                  s_next.addr = {PAGE0, s_reg.stk};
                  s_next.wdata = s_reg.pc[7:0];
                  s_next.we = 1'b1;
                  s_next.st = S_PUSH_LO;
               end else if (s_reg.opc == OP_A2X) begin
                  s_next.idx = s_reg.acc;
               end else if (s_reg.opc == OP_X2A) begin
                  s_next.acc = s_reg.idx;
               end else if (s_reg.opc == OP_WAIT) begin
                  s_next.cond[CC_I] = 1'b0;
                  s_next.wt = 1'b1;
                  s_next.st = S_WAIT;
               end else if (s_reg.opc == OP_TEST_ACC) begin
                  s_next.cond = set_nz(s_reg.cond, s_reg.acc);
               end else if (s_reg.opc == OP_TEST_IDX) begin
                  s_next.cond = set_nz(s_reg.cond, s_reg.idx);
               end else begin
                  unique case (mode)
                     M_IMMED: begin
                        s_next.acc = diff;
                        s_next.cond = set_nz(s_reg.cond, diff);
                        s_next.cond[CC_C] = borrow;
                        s_next.pc = pc_inc;
                        s_next.addr = pc_inc;
                     end
                     M_DIR: begin
                        s_next.addr = {PAGE0, i_mem_rdata};
                        s_next.pc = pc_inc;
                        s_next.st = S_EXEC;
                     end
                     M_EXTD, M_XLONG: begin
                        s_next.hi = i_mem_rdata;
                        s_next.pc = pc_inc;
                        s_next.addr = pc_inc;
                        s_next.st = S_LO;
                     end
                     M_XSHORT: begin
                        s_next.addr = {PAGE0, i_mem_rdata} +
                                      {PAGE0, s_reg.idx};
                        s_next.pc = pc_inc;
                        s_next.st = S_EXEC;
                     end
                     M_XPLAIN: begin
                        s_next.addr = {PAGE0, s_reg.idx};
                        s_next.st = S_EXEC;
                     end
                     M_NONE: begin
                        s_next.st = S_FETCH;
                     end
                  endcase
               end
            end
            S_LO: begin
               if (mode == M_XLONG) begin
                  s_next.addr = {s_reg.hi, i_mem_rdata} +
                                {PAGE0, s_reg.idx};
               end else begin
                  s_next.addr = {s_reg.hi, i_mem_rdata};
               end
               s_next.pc = pc_inc;
               s_next.st = S_EXEC;
            end
            S_EXEC: begin
               if (is_sub(s_reg.opc)) begin
                  s_next.acc = diff;
                  s_next.cond = set_nz(s_reg.cond, diff);
                  s_next.cond[CC_C] = borrow;
               end else begin
                  s_next.cond = set_nz(s_reg.cond, i_mem_rdata);
               end
               s_next.addr = s_reg.pc;
               s_next.st = S_FETCH;
            end
            S_PUSH_LO: begin
               s_next.stk = stk_dec;
               s_next.addr = {PAGE0, stk_dec};
               s_next.wdata = s_reg.pc[15:8];
               s_next.we = 1'b1;
               s_next.st = S_PUSH_HI;
            end
            S_PUSH_HI: begin
               s_next.stk = stk_dec;
               s_next.addr = {PAGE0, stk_dec};
               s_next.wdata = s_reg.idx;
               s_next.we = 1'b1;
               s_next.st = S_PUSH_X;
            end
            S_PUSH_X: begin
               s_next.stk = stk_dec;
               s_next.addr = {PAGE0, stk_dec};
               s_next.wdata = s_reg.acc;
               s_next.we = 1'b1;
               s_next.st = S_PUSH_A;
            end
            S_PUSH_A: begin
               s_next.stk = stk_dec;
               s_next.addr = {PAGE0, stk_dec};
               s_next.wdata = s_reg.cond;
               s_next.we = 1'b1;
               s_next.st = S_PUSH_CC;
            end
            S_PUSH_CC: begin
               s_next.stk = stk_dec;
               s_next.cond[CC_I] = 1'b1;
               s_next.addr = VEC_HI;
               s_next.st = S_VHI;
            end
            S_VHI: begin
               s_next.pc[15:8] = i_mem_rdata;
               s_next.addr = VEC_LO;
               s_next.st = S_VLO;
            end
            S_VLO: begin
               s_next.pc[7:0] = i_mem_rdata;
               s_next.st = S_VDN;
            end
            S_VDN: begin
               s_next.addr = s_reg.pc;
               s_next.st = S_FETCH;
            end
            S_WAIT: begin
               if (s_reg.wake_s2) begin
                  s_next.wt = 1'b0;
                  s_next.addr = s_reg.pc;
                  s_next.st = S_FETCH;
               end
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // State register
   always_ff @(posedge i_clk) begin
      s_reg <= s_next;
   end

   assign o_mem_addr = s_reg.addr;
   assign o_mem_wdata = s_reg.wdata;
   assign o_mem_we = s_reg.we;
   assign o_acc = s_reg.acc;
   assign o_index = s_reg.idx;
   assign o_stack_ptr = s_reg.stk;
   assign o_pc = s_reg.pc;
   assign o_cond_codes = s_reg.cond;
   assign o_wait = s_reg.wt;

   ////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (i_reset);
   localparam int TRAP_TAIL = TRAP_CYCLES - 1;

   AST_SUB_RESULT:
   assert property ((s_reg.st == S_EXEC) && is_sub(s_reg.opc) |=>
      (s_reg.acc == 8'($past(s_reg.acc) - $past(i_mem_rdata))) &&
      (s_reg.cond[CC_C] == ($past(i_mem_rdata) > $past(s_reg.acc))))
      else $error("Subtract result or borrow wrong");

   AST_TRAP_PUSH:
   assert property ((s_reg.st == S_DEC) && (s_reg.opc == OP_TRAP) |=>
      o_mem_we && (o_mem_wdata == $past(s_reg.pc[7:0])) &&
      (o_mem_addr == {PAGE0, $past(s_reg.stk)}) ##1
      o_mem_we && (o_mem_addr == {PAGE0, 8'($past(s_reg.stk, 2) - ONE8)}))
      else $error("Trap push order or address wrong");

   AST_TRAP_LEN:
   assert property ((s_reg.st == S_DEC) && (s_reg.opc == OP_TRAP) |->
      ##TRAP_TAIL (s_reg.st == S_FETCH) && s_reg.cond[CC_I] &&
      (s_reg.stk == 8'($past(s_reg.stk, TRAP_TAIL) - 8'h05)))
      else $error("Trap length, mask or stack depth wrong");

   AST_A2X:
   assert property ((s_reg.st == S_DEC) && (s_reg.opc == OP_A2X) |=>
      (s_reg.idx == $past(s_reg.acc)) && $stable(s_reg.cond) &&
      (s_reg.st == S_FETCH))
      else $error("Acc to index copy wrong");

   AST_X2A:
   assert property ((s_reg.st == S_DEC) && (s_reg.opc == OP_X2A) |=>
      (s_reg.acc == $past(s_reg.idx)) && $stable(s_reg.cond) &&
      (s_reg.st == S_FETCH))
      else $error("Index to acc copy wrong");

   AST_TEST:
   assert property ((s_reg.st == S_EXEC) && !is_sub(s_reg.opc) |=>
      $stable(s_reg.acc) &&
      (s_reg.cond[CC_Z] == ($past(i_mem_rdata) == ZERO8)) &&
      (s_reg.cond[CC_N] == $past(i_mem_rdata[7])))
      else $error("Test flags wrong or result stored");

   AST_WAIT:
   assert property ((s_reg.st == S_DEC) && (s_reg.opc == OP_WAIT) |=>
      o_wait && !s_reg.cond[CC_I] && $stable(s_reg.pc))
      else $error("Wait did not halt or unmask");

   AST_EXTD_ADDR:
   assert property ((s_reg.st == S_LO) && (mode == M_EXTD) |=>
      (o_mem_addr == {$past(s_reg.hi), $past(i_mem_rdata)}) &&
      (s_reg.st == S_EXEC))
      else $error("Extended address wrong");

   AST_XLONG_ADDR:
   assert property ((s_reg.st == S_LO) && (mode == M_XLONG) |=>
      (o_mem_addr == {$past(s_reg.hi), $past(i_mem_rdata)} +
       {PAGE0, $past(s_reg.idx)}))
      else $error("Long indexed address wrong");

   AST_XSHORT_ADDR:
   assert property ((s_reg.st == S_DEC) && (mode == M_XSHORT) |=>
      (o_mem_addr == {PAGE0, $past(i_mem_rdata)} +
       {PAGE0, $past(s_reg.idx)}) && (s_reg.pc == $past(pc_inc)))
      else $error("Short indexed address wrong");

   AST_DIR_ADDR:
   assert property ((s_reg.st == S_DEC) && (mode == M_DIR) |=>
      (o_mem_addr == {PAGE0, $past(i_mem_rdata)}))
      else $error("Direct address wrong");

   AST_XPLAIN_ADDR:
   assert property ((s_reg.st == S_DEC) && (mode == M_XPLAIN) |=>
      (o_mem_addr == {PAGE0, $past(s_reg.idx)}) && $stable(s_reg.pc))
      else $error("Plain indexed address wrong");

endmodule : cst_decoder
`default_nettype wire

// ===== hw/cst_sub_alu.sv
// Eight-bit subtractor with borrow out
`timescale 1ns/10ps
`default_nettype none
module cst_sub_alu (
   input wire logic [7:0] i_a,
   input wire logic [7:0] i_b,
   output logic [7:0] o_diff,
   output logic o_borrow
);
   logic [8:0] wide;
   always_comb begin
      wide = {1'b0, i_a} - {1'b0, i_b};
      o_diff = wide[7:0];
      o_borrow = wide[8];
   end
endmodule : cst_sub_alu
`default_nettype wire

// ===== tb/cst_mem_model.sv
// Combinational-read program and data memory for the decoder bench
`timescale 1ns/10ps
`default_nettype none
module cst_mem_model (
   input wire logic i_clk,
   input wire logic [15:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic i_we,
   output logic [7:0] o_rdata
);
   ////////////////////////////////////////////////////////////////////////
   // Storage, loaded by the bench between runs
   logic [7:0] mem [0:65535];

   // Read answers in the same cycle as the address
   assign o_rdata = mem[i_addr];

   // Write lands on the edge that ends the strobe cycle
   always @(posedge i_clk) begin
      if (i_we === 1'b1) begin
         mem[i_addr] <= i_wdata;
      end
   end
endmodule : cst_mem_model
`default_nettype wire

// ===== tb/tb_cpu_subtract_trap_transfer_decode.sv
// Self-checking bench for the subtract, trap, transfer and test decoder
`timescale 1ns/10ps
`default_nettype none
module tb_cpu_subtract_trap_transfer_decode;
   import cst_pkg::*;
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic wake = 1'b0;
   logic [15:0] mem_addr;
   logic [7:0] mem_wdata;
   logic mem_we;
   logic [7:0] rdata;
   logic [7:0] acc;
   logic [7:0] idx;
   logic [7:0] stk;
   logic [15:0] pc;
   logic [7:0] cond;
   logic waiting;
   int err_total = 0;
   int compares = 0;
   int wes = 0;

   ////////////////////////////////////////////////////////////////////////
   // Clock and instances
   always #10 clk = ~clk;

   cst_decoder cst_decoder_inst (
      .i_clk(clk),
      .i_reset(reset),
      .i_mem_rdata(rdata),
      .i_wake(wake),
      .o_mem_addr(mem_addr),
      .o_mem_wdata(mem_wdata),
      .o_mem_we(mem_we),
      .o_acc(acc),
      .o_index(idx),
      .o_stack_ptr(stk),
      .o_pc(pc),
      .o_cond_codes(cond),
      .o_wait(waiting)
   );

   cst_mem_model cst_mem_model_inst (
      .i_clk(clk),
      .i_addr(mem_addr),
      .i_wdata(mem_wdata),
      .i_we(mem_we),
      .o_rdata(rdata)
   );

   ////////////////////////////////////////////////////////////////////////
   // Shared tasks
   task automatic wrap_up;
      if (err_total == 0 && compares > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : wrap_up

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp) begin
         err_total++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk

   task automatic load(input logic [15:0] a, input int n,
                       input logic [127:0] v);
      for (int i = 0; i < n; i++) begin
         cst_mem_model_inst.mem[a + 16'(i)] = v[8 * (n - 1 - i) +: 8];
      end
   endtask : load

   task automatic start(input logic [15:0] a, input int n,
                        input logic [127:0] v);
      @(negedge clk);
      reset = 1'b1;
      for (int i = 0; i < 65536; i++) begin
         cst_mem_model_inst.mem[i] = 8'h00;
      end
      load(a, n, v);
      repeat (4) @(negedge clk);
      reset = 1'b0;
   endtask : start

   task automatic step(input int n);
      for (int k = 0; k < n; k++) begin
         @(posedge clk);
         @(negedge clk);
         if (mem_we === 1'b1) begin
            wes++;
         end
      end
   endtask : step

   task automatic ins(input int n, input logic [7:0] a, input logic [7:0] x,
                      input logic [7:0] c, input logic [15:0] p);
      step(n);
      chk(acc, a);
      chk(idx, x);
      chk(cond, c);
      chk(pc, p);
   endtask : ins

   ////////////////////////////////////////////////////////////////////////
   // Scenarios
   task automatic run_transfers;
      start(16'h0100, 7, {8'ha0, 8'h03, 8'h97, 8'ha0, 8'hfd, 8'h9f, 8'h4d});
      ins(2, 8'hfd, 8'h00, 8'hfd, 16'h0102);
      ins(XFER_CYCLES, 8'hfd, 8'hfd, 8'hfd, 16'h0103);
      ins(2, 8'h00, 8'hfd, 8'hfa, 16'h0105);
      ins(XFER_CYCLES, 8'hfd, 8'hfd, 8'hfa, 16'h0106);
      ins(2, 8'hfd, 8'hfd, 8'hfc, 16'h0107);
   endtask : run_transfers

   task automatic run_modes;
      start(16'h0100, 16, {8'ha0, 8'hf0, 8'h97, 8'hb0, 8'h40, 8'hc0, 8'h12,
            8'h34, 8'hd0, 8'h20, 8'h00, 8'he0, 8'h05, 8'hf0, 8'h3d, 8'h40});
      load(16'h0110, 4, {8'h6d, 8'h08, 8'h5d, 8'h7d});
      load(16'h0040, 1, 8'h03);
      load(16'h1234, 1, 8'h01);
      load(16'h2010, 1, 8'h02);
      load(16'h0015, 1, 8'h09);
      load(16'h0010, 1, 8'h81);
      ins(2, 8'h10, 8'h00, 8'hf9, 16'h0102);
      ins(2, 8'h10, 8'h10, 8'hf9, 16'h0103);
      ins(3, 8'h0d, 8'h10, 8'hf8, 16'h0105);
      ins(4, 8'h0c, 8'h10, 8'hf8, 16'h0108);
      ins(4, 8'h0a, 8'h10, 8'hf8, 16'h010b);
      ins(3, 8'h01, 8'h10, 8'hf8, 16'h010d);
      ins(3, 8'h80, 8'h10, 8'hfd, 16'h010e);
      ins(3, 8'h80, 8'h10, 8'hf9, 16'h0110);
      ins(3, 8'h80, 8'h10, 8'hfb, 16'h0112);
      ins(2, 8'h80, 8'h10, 8'hf9, 16'h0113);
      ins(3, 8'h80, 8'h10, 8'hfd, 16'h0114);
   endtask : run_modes

   task automatic run_wait_trap;
      int k;
      start(16'h0100, 5, {8'h8f, 8'ha0, 8'h03, 8'h97, 8'h83});
      load(16'hfffc, 2, {8'h12, 8'h34});
      step(3);
      chk(waiting, 1'b1);
      chk(cond, 8'hf0);
      step(4);
      chk(waiting, 1'b1);
      chk(pc, 16'h0101);
      wake = 1'b1;
      k = 0;
      while (waiting !== 1'b0 && k < 8) begin
         step(1);
         k++;
      end
      wake = 1'b0;
      if (k == 8) begin
         err_total++;
         wrap_up();
      end
      k = 0;
      while (idx !== 8'hfd && k < 20) begin
         step(1);
         k++;
      end
      if (k == 20) begin
         err_total++;
         wrap_up();
      end
      chk(cond, 8'hf5);
      wes = 0;
      step(TRAP_CYCLES);
      chk(pc, 16'h1234);
      chk(mem_addr, 16'h1234);
      chk(cond, 8'hfd);
      chk(stk, 8'hfa);
      chk(16'(wes), 16'h0005);
      chk(cst_mem_model_inst.mem[16'h00ff], 8'h05);
      chk(cst_mem_model_inst.mem[16'h00fe], 8'h01);
      chk(cst_mem_model_inst.mem[16'h00fd], 8'hfd);
      chk(cst_mem_model_inst.mem[16'h00fc], 8'hfd);
      chk(cst_mem_model_inst.mem[16'h00fb], 8'hf5);
      step(1);
      chk(pc, 16'h1235);
   endtask : run_wait_trap

   ////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      run_transfers();
      run_modes();
      run_wait_trap();
      wrap_up();
   end
endmodule : tb_cpu_subtract_trap_transfer_decode
`default_nettype wire
